// ### design/mlcd_top.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "mlcd_consts.svh"

// ============================================================
// Contract
// RQ1: Row-and-column words are 40 bits with row address in bits 1..n.
// RQ2: Segment-only words are 48 bits with row address in bits 1..8.
// RQ3: Each set address bit k write-enables memory row k only.
// RQ4: Several set address bits write the same data into every such row.
// RQ5: The host drives the alternation input at n times the refresh rate.
// RQ6: In row mode outputs 1..n are rows and the rest are columns from 1.
// RQ7: With two rows output 3 is column 1; else output 3 is row 3.
// RQ8: In segment-only mode every output k is column k, no rows.
// RQ9: The commit pulse writes memory, blanks output and resyncs frames.
// RQ10: The alternation input level sets the drive polarity.
// RQ11: An active-low mode pin selects column-only operation.
// RQ12: Serial input shifts on the falling clock edge, output on rising.
// RQ13: Serial output is serial input delayed by 40 or 48 periods.
// RQ14: The host sends the highest bit first and address bits last.
// RQ15: An all-zero address writes no row and only synchronises.
// RQ16: The scan steps one row per alternation period and wraps after n.
module mlcd_top #(
    parameter int ROWS = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    input  wire logic        commit_pulse,
    input  wire logic        polarity_alternation_input,
    input  wire logic        col_only_n,
    output logic             serial_out,
    output logic [39:0]      drive_outputs,
    output logic [39:0]      drive_row_mask,
    output logic             drive_polarity,
    output logic             drive_blank,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    localparam logic [7:0] ROW_ADDR_MASK = 8'((1 << ROWS) - 1);
    localparam logic [2:0] LAST_ROW      = 3'(ROWS - 1);

    // ============================================================
    // Serial link
    mlcd_link_if u_link_if ();

    mlcd_shift u_shift (
        .serial_clk (serial_clk),
        .aresetn    (aresetn),
        .serial_in  (serial_in),
        .col_only_n (col_only_n),
        .serial_out (serial_out),
        .lnk        (u_link_if.link)
    );

    // ============================================================
    // Pin synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       commit_s;
    logic       alt_s;
    logic       seg_only;
    logic       commit_d_q;
    logic       alt_d_q;
    logic       commit_fall;
    logic       alt_fall;

    always_ff @(posedge aclk) begin
        sync1_q <= {col_only_n, polarity_alternation_input, commit_pulse};
        sync2_q <= sync1_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            commit_d_q <= 1'b0;
            alt_d_q    <= 1'b0;
        end else begin
            commit_d_q <= commit_s;
            alt_d_q    <= alt_s;
        end
    end

    assign commit_s    = sync2_q[0];
    assign alt_s       = sync2_q[1];
    assign seg_only    = ~sync2_q[2]; // RQ11
    assign commit_fall = commit_d_q & ~commit_s;
    assign alt_fall    = alt_d_q & ~alt_s;

    // ============================================================
    // Word decode
    // The shift word is read without a handshake: the host may not
    // clock again until well after the strobe falls, which outlasts
    // the synchroniser delay, so the word is still at the fall.
    logic [47:0] word;
    logic [7:0]  wr_addr;
    logic [39:0] wr_data;
    logic [39:0] rowcol_data;

    assign word        = u_link_if.word;
    assign rowcol_data = 40'(word[39:0] >> ROWS); // RQ1
    assign wr_data     = seg_only ? word[47:8] : rowcol_data; // RQ2
    assign wr_addr     = seg_only ? word[7:0]
                                  : (word[7:0] & ROW_ADDR_MASK); // RQ1 RQ2

    // ============================================================
    // Display memory
    logic [39:0] mem_q [`MLCD_MEM_ROWS];

    genvar gr;
    generate
        for (gr = 0; gr < `MLCD_MEM_ROWS; gr++) begin : g_row
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    mem_q[gr] <= 40'h00_0000_0000;
                end else if (commit_fall && wr_addr[gr]) begin
                    mem_q[gr] <= wr_data; // RQ3 RQ4 RQ9 RQ15
                end
            end
        end
    endgenerate

    // ============================================================
    // Control register and refresh scan
    logic [1:0]  ctrl_q;
    logic [2:0]  row_q;
    logic [2:0]  row_d;
    logic        sync_pend_q;
    logic [15:0] commits_q;
    logic        scan_en;

    assign scan_en = ctrl_q[`MLCD_CTRL_SCAN_EN];

    // Strobe high forces the next frame to start from row 1
    assign row_d = (sync_pend_q || commit_s || row_q == LAST_ROW)
                 ? 3'h0 : 3'(row_q + 3'h1); // RQ16 RQ9

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_q <= 3'h0;
        end else if (alt_fall && scan_en) begin
            row_q <= row_d; // RQ16
        end
    end

    // Set wins over the clear at the frame edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_pend_q <= 1'b0;
        end else if (commit_s) begin
            sync_pend_q <= 1'b1; // RQ9
        end else if (alt_fall && scan_en) begin
            sync_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            commits_q <= 16'h0000;
        end else if (commit_fall && wr_addr != 8'h00) begin
            commits_q <= 16'(commits_q + 16'h0001);
        end
    end

    // ============================================================
    // Output mapping
    logic [39:0] row_data;
    logic [7:0]  row_sel;
    logic [39:0] drive_d;
    logic [39:0] mask_d;

    assign row_data = mem_q[row_q]; // RQ16
    assign row_sel  = 8'(8'h01 << row_q);

    genvar gi;
    generate
        for (gi = 0; gi < `MLCD_COLS; gi++) begin : g_out
            if (gi < ROWS) begin : g_rowpin
                assign drive_d[gi] = seg_only ? row_data[gi]
                                              : row_sel[gi]; // RQ6 RQ7 RQ8
                assign mask_d[gi]  = ~seg_only; // RQ6
            end else begin : g_colpin
                assign drive_d[gi] = seg_only ? row_data[gi]
                                   : row_data[gi-ROWS]; // RQ6 RQ7 RQ8
                assign mask_d[gi]  = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_outputs  <= 40'h00_0000_0000;
            drive_row_mask <= 40'h00_0000_0000;
            drive_polarity <= 1'b0;
            drive_blank    <= 1'b1;
        end else begin
            drive_outputs  <= drive_d;
            drive_row_mask <= mask_d;
            drive_polarity <= alt_s; // RQ10
            drive_blank    <= commit_s | ctrl_q[`MLCD_CTRL_BLANK]; // RQ9
        end
    end

    // ============================================================
    // AXI4-Lite write channel
    logic [7:0]  awaddr_q;
    logic        aw_full_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_full_q;
    logic        do_write;
    logic        wr_ctrl;

    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready  = ~w_full_q;
    assign do_write      = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_ctrl       = awaddr_q == `MLCD_CTRL_OFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (do_write) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `MLCD_CTRL_RESET;
        end else if (do_write && wr_ctrl && wstrb_q[0]) begin
            ctrl_q <= wdata_q[1:0];
        end
    end

    // Only the control word is writable; other writes get an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= mlcd_pkg::MLCD_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ctrl ? mlcd_pkg::MLCD_RESP_OKAY
                                    : mlcd_pkg::MLCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ============================================================
    // AXI4-Lite read channel
    logic        rd_ctrl;
    logic        rd_status;
    logic        rd_commits;
    logic        rd_row;
    logic        rd_hit;
    logic [31:0] status_w;
    logic [31:0] rdata_w;

    assign rd_ctrl    = s_axi_araddr == `MLCD_CTRL_OFF;
    assign rd_status  = s_axi_araddr == `MLCD_STATUS_OFF;
    assign rd_commits = s_axi_araddr == `MLCD_COMMITS_OFF;
    assign rd_row     = (s_axi_araddr[7:5] == `MLCD_ROWS_BASE)
                      && (s_axi_araddr[1:0] == 2'h0);
    assign rd_hit     = rd_ctrl | rd_status | rd_commits | rd_row;

    assign status_w = {25'h000_0000, sync_pend_q, commit_s, alt_s,
                       seg_only, row_q};

    // Row words return their low 32 columns only
    assign rdata_w = rd_ctrl    ? {30'h0000_0000, ctrl_q}
                   : rd_status  ? status_w
                   : rd_commits ? {16'h0000, commits_q}
                   : rd_row     ? mem_q[s_axi_araddr[4:2]][31:0]
                   : 32'h0000_0000;

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= mlcd_pkg::MLCD_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_w;
            s_axi_rresp  <= rd_hit ? mlcd_pkg::MLCD_RESP_OKAY
                                   : mlcd_pkg::MLCD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : mlcd_top

// ### design/mlcd_consts.svh
`ifndef MLCD_CONSTS_SVH
`define MLCD_CONSTS_SVH

// ============================================================
// Word and memory geometry
`define MLCD_COLS          40
`define MLCD_MEM_ROWS      8
`define MLCD_LEN_ROWCOL    40
`define MLCD_LEN_SEGONLY   48
`define MLCD_SEG_ADDR_BITS 8

// ============================================================
// Register byte offsets
`define MLCD_CTRL_OFF      8'h00
`define MLCD_STATUS_OFF    8'h04
`define MLCD_COMMITS_OFF   8'h08
`define MLCD_ROWS_BASE     3'h1

// ============================================================
// Control fields and reset value
`define MLCD_CTRL_BLANK    0
`define MLCD_CTRL_SCAN_EN  1
`define MLCD_CTRL_RESET    2'h2

// ============================================================
// Status fields
`define MLCD_ST_ROW_LSB    0
`define MLCD_ST_COLONLY    3
`define MLCD_ST_POLARITY   4
`define MLCD_ST_COMMIT     5
`define MLCD_ST_SYNC_PEND  6

`endif

// ### design/mlcd_pkg.sv
package mlcd_pkg;

    typedef enum logic [1:0] {
        MLCD_RESP_OKAY   = 2'h0,
        MLCD_RESP_SLVERR = 2'h2
    } mlcd_resp_t;

    typedef logic [39:0] mlcd_word_t;
    typedef logic [2:0]  mlcd_row_t;

endpackage : mlcd_pkg

// ### design/mlcd_link_if.sv
interface mlcd_link_if;
    logic [47:0] word;

    modport link (output word);
    modport core (input  word);
endinterface : mlcd_link_if

// ### design/mlcd_shift.sv
`include "mlcd_consts.svh"

// ============================================================
// Serial link side, runs only on the serial clock
module mlcd_shift (
    input  wire logic  serial_clk,
    input  wire logic  aresetn,
    input  wire logic  serial_in,
    input  wire logic  col_only_n,
    output logic       serial_out,
    mlcd_link_if.link  lnk
);
    logic [1:0] rst_sync_q;
    logic [1:0] mode_sync_q;
    logic       seg_only;

    // Reset and mode pin brought into the link domain
    always_ff @(negedge serial_clk) begin
        rst_sync_q  <= {rst_sync_q[0], aresetn};
        mode_sync_q <= {mode_sync_q[0], col_only_n};
    end

    assign seg_only = ~mode_sync_q[1]; // RQ11

    // Sample and shift on the falling edge
    always_ff @(negedge serial_clk) begin
        lnk.word <= {lnk.word[46:0], serial_in}; // RQ12 RQ14
    end

    // Chain output on the rising edge, delayed by word length
    always_ff @(posedge serial_clk) begin
        if (!rst_sync_q[1]) begin
            serial_out <= 1'b0;
        end else if (seg_only) begin
            serial_out <= lnk.word[`MLCD_LEN_SEGONLY-1]; // RQ13 RQ12
        end else begin
            serial_out <= lnk.word[`MLCD_LEN_ROWCOL-1]; // RQ13
        end
    end

endmodule : mlcd_shift

// ### verification/mlcd_assertions.sv
// ==========
// Port checker
module mlcd_assertions #(
    parameter int ROWS = 8
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        commit_pulse,
    input wire logic        polarity_alternation_input,
    input wire logic        col_only_n,
    input wire logic [39:0] drive_row_mask,
    input wire logic        drive_polarity,
    input wire logic        drive_blank,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [39:0] ROW_MASK = (40'h1 << ROWS) - 40'h1;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_write_refused: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready && !s_axi_wready) else $error("write not held");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    a_commit_blanks: assert property (
        commit_pulse [*4] |-> drive_blank) else $error("no blank");
    a_polarity_follows: assert property (
        $stable(polarity_alternation_input) [*6]
        |-> drive_polarity == polarity_alternation_input)
        else $error("polarity wrong");
    a_row_drivers: assert property (
        col_only_n [*8] |-> drive_row_mask == ROW_MASK)
        else $error("row mask wrong");
    a_column_only: assert property (
        !col_only_n [*8] |-> drive_row_mask == 40'h0)
        else $error("rows in column mode");
endmodule : mlcd_assertions

bind mlcd_top mlcd_assertions #(.ROWS(ROWS)) i_chk (
    .aclk, .aresetn, .commit_pulse, .polarity_alternation_input,
    .col_only_n, .drive_row_mask, .drive_polarity, .drive_blank,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid
);

// ### verification/mlcd_host_model.sv
// ==========
// Host side of the serial link
module mlcd_host_model (
    output logic      serial_clk,
    output logic      serial_in,
    output logic      commit_pulse,
    output logic      polarity_alternation_input,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [39:0] cap;

    initial begin
        serial_clk = 1'b1;
        serial_in = 1'b0;
        commit_pulse = 1'b0;
        polarity_alternation_input = 1'b0;
        cap = 40'h00_0000_0000;
    end

    // Clock idles high between frames
    task automatic send(input logic [47:0] w, input int len);
        // Offset keeps the link clock off the core clock's edges
        #7;
        for (int i = len - 1; i >= 0; i--) begin
            serial_in = w[i];
            // Taken just before the fall, as a chained input would
            #40 cap = {cap[38:0], serial_out};
            serial_clk = 1'b0;
            #80 serial_clk = 1'b1;
            #40;
        end
        // Released line must not look like held data
        serial_in = ~serial_in;
    endtask : send

    task automatic commit();
        commit_pulse = 1'b1;
        #200 commit_pulse = 1'b0;
        #400;
    endtask : commit

    // Compressed pace: one row per call
    task automatic alt_fall();
        polarity_alternation_input = 1'b1;
        #400 polarity_alternation_input = 1'b0;
        #400;
    endtask : alt_fall
endmodule : mlcd_host_model

// ### verification/mux_lcd_serial_load_and_scan_tb.sv
module mux_lcd_serial_load_and_scan_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int          ROWS = 4;
    localparam logic [35:0] CA = 36'h9_1234_5678;
    localparam logic [35:0] CB = 36'h6_0F0F_A55A;
    localparam logic [39:0] CC = 40'hC3_5A96_0F81;
    localparam logic [1:0]  OK = mlcd_pkg::MLCD_RESP_OKAY;
    localparam logic [1:0]  ERR = mlcd_pkg::MLCD_RESP_SLVERR;
    logic        aclk, aresetn, col_only_n, serial_clk, serial_in;
    logic        commit_pulse, polarity_alternation_input, serial_out;
    logic [39:0] drive_outputs, drive_row_mask;
    logic        drive_polarity, drive_blank;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [35:0] mem_exp [4];
    int          n_fail, cmp_count;

    mlcd_top #(.ROWS(ROWS)) i_dut (
        .aclk, .aresetn, .serial_clk, .serial_in, .commit_pulse,
        .polarity_alternation_input, .col_only_n, .serial_out,
        .drive_outputs, .drive_row_mask, .drive_polarity, .drive_blank,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    mlcd_host_model i_host (.serial_clk, .serial_in, .commit_pulse,
        .polarity_alternation_input, .serial_out);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ==========
    // Checking and bus tasks
    task automatic end_sim();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic guard(input int n);
        chk(48'(n >= 64), 48'h0);
        if (n >= 64) end_sim();
    endtask : guard

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            // Late ready lets the response be seen while it is held
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 64);
        s_axi_bready <= 1'b0;
        guard(n);
        chk(48'(s_axi_bresp), 48'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        guard(n);
        chk(48'(s_axi_rdata), 48'(ed));
        chk(48'(s_axi_rresp), 48'(er));
    endtask : rd

    task automatic rows_chk();
        for (int r = 0; r < 4; r++) begin
            rd(8'h20 + 8'(4 * r), mem_exp[r][31:0], OK);
        end
    endtask : rows_chk

    // ==========
    // Main sequence
    initial begin
        aresetn = 1'b0;
        col_only_n = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        n_fail = 0;
        cmp_count = 0;
        mem_exp = '{default: '0};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        // Second reset with the link clock running, so the output syncs
        fork
            i_host.send(48'h0, 8);
            begin
                @(posedge aclk);
                aresetn <= 1'b0;
                repeat (24) @(posedge aclk);
                aresetn <= 1'b1;
            end
        join
        rd(8'h00, 32'h0000_0002, OK);
        rd(8'h08, 32'h0000_0000, OK);
        wr(8'h00, 32'h0000_0003, OK);
        repeat (2) @(posedge aclk);
        chk(48'(drive_blank), 48'h1);
        rd(8'h00, 32'h0000_0003, OK);
        wr(8'h00, 32'h0000_0002, OK);
        repeat (2) @(posedge aclk);
        chk(48'(drive_blank), 48'h0);
        wr(8'h04, 32'h0000_0001, ERR);
        rd(8'h40, 32'h0000_0000, ERR);
        i_host.send({CA, 4'h2}, 40);
        i_host.send({CB, 4'h9}, 40);
        chk(48'(i_host.cap), 48'({CA, 4'h2}));
        i_host.commit();
        mem_exp[0] = CB;
        mem_exp[3] = CB;
        rows_chk();
        i_host.send({CA, 4'h0}, 40);
        i_host.commit();
        rows_chk();
        rd(8'h08, 32'h0000_0001, OK);
        i_host.send({CA, 4'h2}, 40);
        i_host.commit();
        mem_exp[1] = CA;
        rows_chk();
        for (int k = 0; k < 5; k++) begin
            i_host.alt_fall();
            rd(8'h04, 32'(k % 4), OK);
            chk(48'(drive_outputs),
                48'({mem_exp[k % 4], 4'(1 << (k % 4))}));
            chk(48'(drive_row_mask), 48'h0F);
            chk(48'(drive_polarity), 48'h0);
        end
        @(posedge aclk);
        col_only_n <= 1'b0;
        repeat (4) @(posedge aclk);
        i_host.send(48'h0, 4);
        i_host.send({CC, 8'h81}, 48);
        i_host.commit();
        rd(8'h20, CC[31:0], OK);
        rd(8'h3C, CC[31:0], OK);
        fork
            i_host.alt_fall();
            begin
                repeat (6) @(posedge aclk);
                chk(48'(drive_polarity), 48'h1);
            end
        join
        rd(8'h04, 32'h0000_0008, OK);
        chk(48'(drive_outputs), 48'(CC));
        chk(48'(drive_row_mask), 48'h0);
        end_sim();
    end
endmodule : mux_lcd_serial_load_and_scan_tb
